// [rtl/esst_pkg.sv]
// Package with constants and types for the enclave security state tracker
`default_nettype none
package esst_pkg;
  localparam logic [11:0] ESST_STATUS_ADDR   = 12'h500;
  localparam int          ESST_LOCK_BIT      = 0;
  localparam int          ESST_THR_LSB       = 16;
  localparam int          ESST_THR_W         = 8;
  localparam int          ESST_DBGCTL_TXDBG  = 15;
  localparam int          ESST_BPCTL_TXDBG   = 11;
  localparam int          ESST_DBGSTAT_TXDBG = 16;
  localparam logic [7:0]  ESST_THR_RESET     = 8'h00;
  localparam int          ESST_SLEEP_S3      = 3;
  localparam int          ESST_SLEEP_S5      = 5;
  typedef enum logic [1:0] {ESST_TXN_NONE, ESST_TXN_ELIDE, ESST_TXN_RESTRICT} esst_txn_t;
  typedef enum {ESST_RUN, ESST_PAUSE, ESST_WAIT_START} esst_rsp_t;
endpackage
`default_nettype wire

// [rtl/esst_status_reg.sv]
// Read-only launch version status register with lock and threshold
`default_nettype none
module esst_status_reg
  import esst_pkg::*;
(
  input  wire logic        clk,          // Core clock
  input  wire logic        rstn,         // Sync reset, active low
  input  wire logic [7:0]  fw_threshold, // Threshold from firmware
  input  wire logic        fw_load,      // Firmware load strobe
  input  wire logic        lock_evt,     // Successful enclave instruction
  input  wire logic        safer_mode,   // Safer mode capability present
  input  wire logic        rd_en,        // Register read strobe
  input  wire logic [11:0] rd_addr,      // Register address
  output logic [63:0]      rd_data,      // Read data
  output logic             locked,       // Lock bit
  output logic [7:0]       threshold     // Current threshold
);
  ////////////////////////////////////////////////////////////////////////
  // Threshold holds firmware value until the lock is taken
  always_ff @(posedge clk)
  begin
    if (!rstn)
      threshold <= ESST_THR_RESET;
    else if (fw_load && !locked)
      threshold <= fw_threshold;
  end

  // Lock is sticky until reset
  always_ff @(posedge clk)
  begin
    if (!rstn)
      locked <= 1'b0;
    else if (lock_evt)
      locked <= 1'b1;
  end

  // Read path; no write port exists, reserved bits zero
  always_ff @(posedge clk)
  begin
    if (!rstn)
      rd_data <= 64'h0;
    else if (rd_en)
    begin
      rd_data <= 64'h0;
      if (rd_addr == ESST_STATUS_ADDR)
      begin
        rd_data[ESST_LOCK_BIT] <= locked;
        rd_data[ESST_THR_LSB +: ESST_THR_W] <= safer_mode ? threshold : 8'h00;
      end
    end
  end

  property p_lock_sticky;
    @(posedge clk) disable iff (!rstn) locked |=> locked;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped");
  property p_thr_frozen;
    @(posedge clk) disable iff (!rstn) locked |=> $stable(threshold);
  endproperty
  a_thr_frozen: assert property (p_thr_frozen) else $error("threshold moved after lock");
  property p_rsvd_zero;
    @(posedge clk) disable iff (!rstn) rd_data[15:1] == 15'h0 && rd_data[63:24] == 40'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
  property p_no_safer;
    @(posedge clk) disable iff (!rstn) rd_en && !safer_mode |=> rd_data[23:16] == 8'h00;
  endproperty
  a_no_safer: assert property (p_no_safer) else $error("threshold shown without capability");
endmodule
`default_nettype wire

// [rtl/esst_txn_ctl.sv]
// Transaction abort and debug handling inside an enclave
`default_nettype none
module esst_txn_ctl
  import esst_pkg::*;
(
  input  wire logic      clk,            // Core clock
  input  wire logic      rstn,           // Sync reset, active low
  input  wire logic      in_enclave,     // Enclave mode
  input  wire logic      opt_in,         // Entry was opt-in
  input  wire esst_txn_t txn,            // Current transaction kind
  input  wire logic      encl_instr,     // Enclave instruction issued
  input  wire logic      fetch_outside,  // Code fetch outside enclave
  input  wire logic      meta_denied,    // Metadata-denied access
  input  wire logic      handler_inside, // Fallback handler in enclave
  input  wire logic      dbg_evt,        // Debug or breakpoint event
  input  wire logic      dbgctl_txdbg,   // Debug control bit 15
  input  wire logic      bpctl_txdbg,    // Breakpoint control bit 11
  output logic           restart_ns,     // Abort and re-run non-speculatively
  output logic           to_fallback,    // Abort to fallback handler
  output logic           prot_fault,     // General protection fault
  output logic           dbg_deliver,    // Debug exception to txn start
  output logic           dbg_abort       // Debug event only aborts
);
  logic in_restrict;
  logic dbg_en;
  logic abort_any;
  assign in_restrict = in_enclave && txn == ESST_TXN_RESTRICT;
  assign dbg_en      = opt_in && dbgctl_txdbg && bpctl_txdbg;
  // No fallback address check happens at transaction begin
  assign abort_any   = in_restrict && (encl_instr || fetch_outside || meta_denied ||
                                       (dbg_evt && !dbg_en));

  ////////////////////////////////////////////////////////////////////////
  // Registered abort outcomes
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      restart_ns  <= 1'b0;
      to_fallback <= 1'b0;
      prot_fault  <= 1'b0;
      dbg_deliver <= 1'b0;
      dbg_abort   <= 1'b0;
    end
    else
    begin
      restart_ns  <= in_enclave && txn == ESST_TXN_ELIDE && encl_instr;
      to_fallback <= abort_any;
      prot_fault  <= abort_any && !handler_inside;
      dbg_deliver <= in_restrict && dbg_evt && dbg_en;
      dbg_abort   <= in_restrict && dbg_evt && !dbg_en;
    end
  end

  property p_optout;
    @(posedge clk) disable iff (!rstn)
      in_restrict && dbg_evt && !opt_in |=> dbg_abort && !dbg_deliver;
  endproperty
  a_optout: assert property (p_optout) else $error("opt-out debug delivered");
  property p_fetch;
    @(posedge clk) disable iff (!rstn)
      in_restrict && fetch_outside && handler_inside |=> to_fallback && !prot_fault;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch abort wrong");
  property p_outside_handler;
    @(posedge clk) disable iff (!rstn)
      in_restrict && meta_denied && !handler_inside |=> to_fallback && prot_fault;
  endproperty
  a_outside_handler: assert property (p_outside_handler) else $error("outside handler no fault");
  c_deliver: cover property (@(posedge clk) disable iff (!rstn) dbg_deliver);
  c_elide: cover property (@(posedge clk) disable iff (!rstn) restart_ns);
endmodule
`default_nettype wire

// [rtl/esst_top.sv]
// Top of the enclave security state tracker
`default_nettype none
module esst_top
  import esst_pkg::*;
(
  input  wire logic          clk,             // Core clock, 25 MHz
  input  wire logic          rstn,            // Sync reset, active low
  input  wire logic          safer_mode,      // Safer mode capability present
  input  wire logic [7:0]    fw_threshold,    // Firmware version threshold
  input  wire logic          fw_load,         // Firmware threshold load
  input  wire logic          reg_rd,          // Status register read
  input  wire logic [11:0]   reg_addr,        // Status register address
  output logic [63:0]        reg_rdata,       // Status read data
  input  wire logic          enter,           // Enclave entry done
  input  wire logic          enter_opt_in,    // Entry is opt-in
  input  wire logic          leave,           // Enclave exit done
  input  wire logic          encl_instr,      // Enclave instruction issued
  input  wire logic          encl_ok,         // It completed without error
  input  wire logic          launch_instr,    // Secure launch instruction
  input  wire logic          entry_leaf_evt,  // Launch entry leaf event
  input  wire logic          exit_leaf_busy,  // Launch exit leaf running
  input  wire logic          startup_sig,     // Startup signal
  input  wire logic          launch_req,      // Module launch request
  input  wire logic [7:0]    module_version,  // Module version number
  input  wire logic          dma_req,         // DMA request
  input  wire logic          dma_in_reserved, // DMA hits reserved memory
  input  wire esst_txn_t     txn,             // Transaction kind
  input  wire logic          fetch_outside,   // Fetch outside enclave
  input  wire logic          meta_denied,     // Metadata-denied access
  input  wire logic          handler_inside,  // Fallback handler in enclave
  input  wire logic          dbg_evt,         // Debug or breakpoint event
  input  wire logic          dbgctl_txdbg,    // Debug control bit 15
  input  wire logic          bpctl_txdbg,     // Breakpoint control bit 11
  input  wire logic          vm_exit,         // Debug causes VM exit
  input  wire logic [2:0]    sleep_state,     // Sleep state entered
  input  wire logic          sleep_enter,     // Sleep entry strobe
  input  wire logic          mcheck_exc,      // Machine check exception
  input  wire logic          cc_int,          // Corrected check interrupt
  input  wire logic          bank_ctl_clear,  // Bank control bit cleared 1 to 0
  output logic               dma_block,       // DMA access refused
  output logic               invalid_opcode,  // Invalid opcode fault
  output logic               async_exit,      // Async enclave exit
  output logic               paused,          // Paused for exit leaf
  output logic               wait_startup,    // Waiting for startup signal
  output logic               launch_ok,       // Module launch allowed
  output logic               launch_shutdown, // Launch rejected, shutdown
  output logic               flush_xlat,      // Flush translation context
  output logic               clear_monitor,   // Clear address monitor
  output logic               restart_ns,      // Re-run non-speculatively
  output logic               to_fallback,     // Abort to fallback handler
  output logic               prot_fault,      // General protection fault
  output logic               dbg_deliver,     // Debug exception delivered
  output logic               dbg_abort,       // Debug event only aborts
  output logic               dbgstat_clr16,   // Clear debug status bit 16
  output logic               pend_dbg16,      // Set pending debug bit 16
  output logic               enclaves_lost,   // All enclaves destroyed
  output logic               in_enclave,      // Enclave mode
  output logic               feature_en       // Capability flag
);
  logic       locked;
  logic [7:0] threshold;
  logic       opt_in_r;
  logic       enabled_once_r;
  logic       dbg_any;
  esst_rsp_t  rsp_r;
  esst_rsp_t  rsp_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Status register
  esst_status_reg u_status (
    .clk          (clk),
    .rstn         (rstn),
    .fw_threshold (fw_threshold),
    .fw_load      (fw_load),
    .lock_evt     (encl_instr && encl_ok && feature_en),
    .safer_mode   (safer_mode),
    .rd_en        (reg_rd),
    .rd_addr      (reg_addr),
    .rd_data      (reg_rdata),
    .locked       (locked),
    .threshold    (threshold)
  );

  // Transaction handling
  esst_txn_ctl u_txn (
    .clk            (clk),
    .rstn           (rstn),
    .in_enclave     (in_enclave),
    .opt_in         (opt_in_r),
    .txn            (txn),
    .encl_instr     (encl_instr),
    .fetch_outside  (fetch_outside),
    .meta_denied    (meta_denied),
    .handler_inside (handler_inside),
    .dbg_evt        (dbg_evt),
    .dbgctl_txdbg   (dbgctl_txdbg),
    .bpctl_txdbg    (bpctl_txdbg),
    .restart_ns     (restart_ns),
    .to_fallback    (to_fallback),
    .prot_fault     (prot_fault),
    .dbg_deliver    (dbg_any),
    .dbg_abort      (dbg_abort)
  );

  ////////////////////////////////////////////////////////////////////////
  // DMA guard
  always_ff @(posedge clk)
  begin
    if (!rstn)
      dma_block <= 1'b0;
    else
      dma_block <= dma_req && dma_in_reserved;
  end

  // Launch instruction fault inside enclave
  always_ff @(posedge clk)
  begin
    if (!rstn)
      invalid_opcode <= 1'b0;
    else
      invalid_opcode <= launch_instr && in_enclave;
  end

  // Module launch check against threshold
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      launch_ok       <= 1'b0;
      launch_shutdown <= 1'b0;
    end
    else
    begin
      launch_ok       <= launch_req && (!locked || module_version >= threshold);
      launch_shutdown <= launch_req && locked && module_version < threshold;
    end
  end

  // Responding processor state
  always_comb
  begin
    rsp_nxt = rsp_r;
    unique case (rsp_r)
      ESST_RUN:
        if (entry_leaf_evt)
          rsp_nxt = ESST_WAIT_START;
        else if (exit_leaf_busy && in_enclave)
          rsp_nxt = ESST_PAUSE;
      ESST_PAUSE:
        if (!exit_leaf_busy)
          rsp_nxt = ESST_RUN;
      ESST_WAIT_START:
        if (startup_sig)
          rsp_nxt = ESST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      rsp_r <= ESST_RUN;
    else
      rsp_r <= rsp_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      paused       <= 1'b0;
      wait_startup <= 1'b0;
    end
    else
    begin
      paused       <= rsp_nxt == ESST_PAUSE;
      wait_startup <= rsp_nxt == ESST_WAIT_START;
    end
  end

  // Asynchronous exit on launch entry, machine check, corrected check interrupt or debug delivery in enclave
  always_ff @(posedge clk)
  begin
    if (!rstn)
      async_exit <= 1'b0;
    else
      async_exit <= in_enclave && (entry_leaf_evt || mcheck_exc || cc_int || dbg_any);
  end

  // Enclave mode and entry kind
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      in_enclave <= 1'b0;
      opt_in_r   <= 1'b0;
    end
    else if (leave || (in_enclave && (entry_leaf_evt || mcheck_exc || cc_int || dbg_any)) ||
             sleep_enter || !feature_en)
      in_enclave <= 1'b0;
    else if (enter)
    begin
      in_enclave <= 1'b1;
      opt_in_r   <= enter_opt_in;
    end
  end

  // Flush and monitor clear on each enter or leave strobe, not on asynchronous exits
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      flush_xlat    <= 1'b0;
      clear_monitor <= 1'b0;
    end
    else
    begin
      flush_xlat    <= enter || leave;
      clear_monitor <= enter || leave;
    end
  end

  // Debug delivery with status bit or pending bit
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      dbg_deliver   <= 1'b0;
      dbgstat_clr16 <= 1'b0;
      pend_dbg16    <= 1'b0;
    end
    else
    begin
      dbg_deliver   <= dbg_any;
      dbgstat_clr16 <= dbg_any && !vm_exit;
      pend_dbg16    <= dbg_any && vm_exit;
    end
  end

  // Sleep loss of enclave memory
  always_ff @(posedge clk)
  begin
    if (!rstn)
      enclaves_lost <= 1'b0;
    else
      enclaves_lost <= sleep_enter && sleep_state >= 3'(ESST_SLEEP_S3) &&
                       sleep_state <= 3'(ESST_SLEEP_S5);
  end

  // Feature disable after machine check or bank clear
  always_ff @(posedge clk)
  begin
    if (!rstn)
      enabled_once_r <= 1'b0;
    else if (feature_en)
      enabled_once_r <= 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      feature_en <= 1'b1;
    else if ((mcheck_exc && enabled_once_r) || bank_ctl_clear)
      feature_en <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_dma;
    @(posedge clk) disable iff (!rstn) dma_req && dma_in_reserved |=> dma_block;
  endproperty
  a_dma: assert property (p_dma) else $error("reserved DMA not blocked");
  property p_bad_opcode;
    @(posedge clk) disable iff (!rstn) launch_instr && in_enclave |=> invalid_opcode;
  endproperty
  a_bad_opcode: assert property (p_bad_opcode) else $error("launch in enclave not faulted");
  property p_entry_wait;
    @(posedge clk) disable iff (!rstn)
      entry_leaf_evt && in_enclave |=> async_exit && wait_startup && !in_enclave;
  endproperty
  a_entry_wait: assert property (p_entry_wait) else $error("entry leaf not handled");
  property p_low_version;
    @(posedge clk) disable iff (!rstn)
      launch_req && locked && module_version < threshold |=> !launch_ok && launch_shutdown;
  endproperty
  a_low_version: assert property (p_low_version) else $error("low version launched");
  property p_flush;
    @(posedge clk) disable iff (!rstn) (enter || leave) |=> flush_xlat && clear_monitor;
  endproperty
  a_flush: assert property (p_flush) else $error("no flush on transition");
  property p_mcheck_exit;
    @(posedge clk) disable iff (!rstn) in_enclave && (mcheck_exc || cc_int) |=> async_exit;
  endproperty
  a_mcheck_exit: assert property (p_mcheck_exit) else $error("machine check no exit");
  property p_disable;
    @(posedge clk) disable iff (!rstn) !feature_en |=> !feature_en;
  endproperty
  a_disable: assert property (p_disable) else $error("feature re-enabled");
  property p_sleep;
    @(posedge clk) disable iff (!rstn) sleep_enter && sleep_state == 3'd4 |=> enclaves_lost;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not destroy");
  property p_version_ok;
    @(posedge clk) disable iff (!rstn)
      launch_req && module_version >= threshold |=> launch_ok && !launch_shutdown;
  endproperty
  a_version_ok: assert property (p_version_ok) else $error("valid version refused");
  property p_unlocked;
    @(posedge clk) disable iff (!rstn) launch_req && !locked |=> launch_ok;
  endproperty
  a_unlocked: assert property (p_unlocked) else $error("unlocked launch refused");
  property p_pause;
    @(posedge clk) disable iff (!rstn)
      rsp_r == ESST_RUN && exit_leaf_busy && in_enclave && !entry_leaf_evt |=> paused;
  endproperty
  a_pause: assert property (p_pause) else $error("no pause for exit leaf");
  property p_resume;
    @(posedge clk) disable iff (!rstn) paused && !exit_leaf_busy |=> !paused;
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after exit leaf");
  property p_mcheck_off;
    @(posedge clk) disable iff (!rstn) mcheck_exc && enabled_once_r |=> !feature_en;
  endproperty
  a_mcheck_off: assert property (p_mcheck_off) else $error("machine check kept feature");
  property p_bank_off;
    @(posedge clk) disable iff (!rstn) bank_ctl_clear |=> !feature_en;
  endproperty
  a_bank_off: assert property (p_bank_off) else $error("bank clear kept feature");
  c_lock: cover property (@(posedge clk) disable iff (!rstn) $rose(locked));
  c_pause: cover property (@(posedge clk) disable iff (!rstn) paused ##1 !paused);
  c_shutdown: cover property (@(posedge clk) disable iff (!rstn) launch_shutdown);
endmodule
`default_nettype wire

// [dv/tb_enclave_security_state_tracker.sv]
// Self-checking testbench for the enclave security state tracker top
`default_nettype none
module tb_enclave_security_state_tracker;
  import esst_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, safer_mode, fw_load, reg_rd, enter, enter_opt_in, leave;
  logic        encl_instr, encl_ok, launch_instr, entry_leaf_evt, exit_leaf_busy, startup_sig;
  logic        launch_req, dma_req, dma_in_reserved, fetch_outside, meta_denied, handler_inside;
  logic        dbg_evt, dbgctl_txdbg, bpctl_txdbg, vm_exit, sleep_enter, mcheck_exc, cc_int;
  logic        bank_ctl_clear;
  logic [7:0]  fw_threshold, module_version, thr, v;
  logic [11:0] reg_addr;
  logic [2:0]  sleep_state;
  esst_txn_t   txn;
  logic [63:0] reg_rdata;
  logic        dma_block, invalid_opcode, async_exit, paused, wait_startup, launch_ok;
  logic        launch_shutdown, flush_xlat, clear_monitor, restart_ns, to_fallback, prot_fault;
  logic        dbg_deliver, dbg_abort, dbgstat_clr16, pend_dbg16, enclaves_lost, in_enclave;
  logic        feature_en;
  logic [6:0]  seen;
  logic [31:0] rng;
  int          failures, tests_run;
  wire  [6:0]  ev = {pend_dbg16, to_fallback, prot_fault, dbg_abort, dbg_deliver, dbgstat_clr16,
                     async_exit};

  ////////////////////////////////////////////////////////////////////////////////
  esst_top uut (
    .clk(clk), .rstn(rstn), .safer_mode(safer_mode), .fw_threshold(fw_threshold),
    .fw_load(fw_load), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .enter(enter), .enter_opt_in(enter_opt_in), .leave(leave), .encl_instr(encl_instr),
    .encl_ok(encl_ok), .launch_instr(launch_instr), .entry_leaf_evt(entry_leaf_evt),
    .exit_leaf_busy(exit_leaf_busy), .startup_sig(startup_sig), .launch_req(launch_req),
    .module_version(module_version), .dma_req(dma_req), .dma_in_reserved(dma_in_reserved),
    .txn(txn), .fetch_outside(fetch_outside), .meta_denied(meta_denied),
    .handler_inside(handler_inside), .dbg_evt(dbg_evt), .dbgctl_txdbg(dbgctl_txdbg),
    .bpctl_txdbg(bpctl_txdbg), .vm_exit(vm_exit), .sleep_state(sleep_state),
    .sleep_enter(sleep_enter), .mcheck_exc(mcheck_exc), .cc_int(cc_int),
    .bank_ctl_clear(bank_ctl_clear), .dma_block(dma_block), .invalid_opcode(invalid_opcode),
    .async_exit(async_exit), .paused(paused), .wait_startup(wait_startup),
    .launch_ok(launch_ok), .launch_shutdown(launch_shutdown), .flush_xlat(flush_xlat),
    .clear_monitor(clear_monitor), .restart_ns(restart_ns), .to_fallback(to_fallback),
    .prot_fault(prot_fault), .dbg_deliver(dbg_deliver), .dbg_abort(dbg_abort),
    .dbgstat_clr16(dbgstat_clr16), .pend_dbg16(pend_dbg16), .enclaves_lost(enclaves_lost),
    .in_enclave(in_enclave), .feature_en(feature_en)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pseudo-random source with a fixed start
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Launch decision expected from lock and threshold: {allowed, shutdown}
  function automatic logic [1:0] launch_exp(input logic lk, input logic [7:0] ver, t);
    return (lk && ver < t) ? 2'b01 : 2'b10;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Inputs change only at the falling edge
  task automatic tick();
    @(negedge clk);
  endtask

  // Gather event pulses over several cycles
  task automatic watch(input int n);
    seen = '0;
    tick();
    dbg_evt = 1'b0;
    meta_denied = 1'b0;
    seen = ev;
    repeat (n - 1)
    begin
      tick();
      seen = seen | ev;
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [63:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    tick();
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    tick();
  endtask

  task automatic launches(input logic lk);
    launch_req = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      rng = xs(rng);
      v = (i < 3) ? thr - 8'h01 + 8'(i) : rng[7:0];
      module_version = v;
      tick();
      chk(64'({launch_ok, launch_shutdown}), 64'(launch_exp(lk, v, thr)));
    end
    launch_req = 1'b0;
  endtask

  task automatic pulse_enter();
    enter = 1'b1;
    tick();
    enter = 1'b0;
  endtask

  // Runaway guard, well beyond the expected run length
  initial
  begin
    repeat (3000) @(posedge clk);
    failures++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {rstn, safer_mode, fw_load, reg_rd, enter, enter_opt_in, leave, encl_instr} = '0;
    {encl_ok, launch_instr, entry_leaf_evt, exit_leaf_busy, startup_sig, launch_req} = '0;
    {dma_req, dma_in_reserved, fetch_outside, meta_denied, handler_inside, dbg_evt} = '0;
    {dbgctl_txdbg, bpctl_txdbg, vm_exit, sleep_enter, mcheck_exc, cc_int, bank_ctl_clear} = '0;
    fw_threshold = 8'h00;
    module_version = 8'h00;
    reg_addr = 12'h000;
    sleep_state = 3'h0;
    txn = ESST_TXN_NONE;
    failures = 0;
    tests_run = 0;
    rng = 32'h000043b4;
    repeat (2) tick();
    rstn = 1'b1;
    chk(64'({feature_en, in_enclave}), 64'h2);
    thr = 8'(xs(rng) & 32'h7f) | 8'h01;
    safer_mode = 1'b1;
    fw_threshold = thr;
    fw_load = 1'b1;
    tick();
    fw_load = 1'b0;
    rd(ESST_STATUS_ADDR, {40'h0, thr, 16'h0000});
    rd(12'h501, 64'h0);
    safer_mode = 1'b0;
    rd(ESST_STATUS_ADDR, 64'h0);
    safer_mode = 1'b1;
    launches(1'b0);
    dma_req = 1'b1;
    dma_in_reserved = 1'b1;
    tick();
    chk(64'(dma_block), 64'h1);
    dma_in_reserved = 1'b0;
    tick();
    chk(64'(dma_block), 64'h0);
    dma_req = 1'b0;
    pulse_enter();
    chk(64'({in_enclave, flush_xlat, clear_monitor}), 64'h7);
    {encl_instr, encl_ok} = 2'b11;
    tick();
    {encl_instr, encl_ok} = 2'b00;
    rd(ESST_STATUS_ADDR, {40'h0, thr, 16'h0001});
    fw_threshold = ~thr;
    fw_load = 1'b1;
    tick();
    fw_load = 1'b0;
    rd(ESST_STATUS_ADDR, {40'h0, thr, 16'h0001});
    launches(1'b1);
    launch_instr = 1'b1;
    tick();
    launch_instr = 1'b0;
    chk(64'(invalid_opcode), 64'h1);
    encl_instr = 1'b1;
    for (int t = 1; t < 3; t++)
    begin
      txn = esst_txn_t'(t);
      tick();
      chk(64'({restart_ns, to_fallback}), 64'(3 - t));
    end
    encl_instr = 1'b0;
    handler_inside = 1'b1;
    fetch_outside = 1'b1;
    tick();
    fetch_outside = 1'b0;
    chk(64'({to_fallback, prot_fault}), 64'h2);
    meta_denied = 1'b1;
    watch(3);
    chk(64'(seen[5:4]), 64'h2);
    handler_inside = 1'b0;
    meta_denied = 1'b1;
    watch(3);
    chk(64'(seen[4]), 64'h1);
    {dbgctl_txdbg, bpctl_txdbg, dbg_evt} = 3'b111;
    watch(4);
    chk(64'(seen[3:2]), 64'h2);
    leave = 1'b1;
    tick();
    leave = 1'b0;
    chk(64'({in_enclave, flush_xlat, clear_monitor}), 64'h3);
    enter_opt_in = 1'b1;
    pulse_enter();
    {dbgctl_txdbg, dbg_evt} = 2'b01;
    watch(4);
    chk(64'(seen[3:2]), 64'h2);
    {dbgctl_txdbg, dbg_evt} = 2'b11;
    watch(4);
    chk(64'({seen[3:0]}), 64'h7);
    vm_exit = 1'b1;
    pulse_enter();
    dbg_evt = 1'b1;
    watch(4);
    vm_exit = 1'b0;
    chk(64'({seen[6], seen[1]}), 64'h2);
    txn = ESST_TXN_NONE;
    pulse_enter();
    sleep_enter = 1'b1;
    for (int s = 0; s < 8; s++)
    begin
      sleep_state = 3'(s);
      tick();
      chk(64'(enclaves_lost), 64'(s >= ESST_SLEEP_S3 && s <= ESST_SLEEP_S5));
    end
    sleep_enter = 1'b0;
    pulse_enter();
    entry_leaf_evt = 1'b1;
    tick();
    entry_leaf_evt = 1'b0;
    chk(64'({async_exit, wait_startup}), 64'h3);
    startup_sig = 1'b1;
    tick();
    startup_sig = 1'b0;
    chk(64'({in_enclave, wait_startup}), 64'h0);
    pulse_enter();
    exit_leaf_busy = 1'b1;
    repeat (3) tick();
    chk(64'(paused), 64'h1);
    exit_leaf_busy = 1'b0;
    tick();
    chk(64'({paused, in_enclave}), 64'h1);
    cc_int = 1'b1;
    tick();
    cc_int = 1'b0;
    chk(64'({async_exit, feature_en}), 64'h3);
    pulse_enter();
    mcheck_exc = 1'b1;
    tick();
    mcheck_exc = 1'b0;
    chk(64'(async_exit), 64'h1);
    tick();
    pulse_enter();
    chk(64'({feature_en, in_enclave}), 64'h0);
    rstn = 1'b0;
    repeat (2) tick();
    rstn = 1'b1;
    tick();
    chk(64'(feature_en), 64'h1);
    rd(ESST_STATUS_ADDR, 64'h0);
    bank_ctl_clear = 1'b1;
    tick();
    bank_ctl_clear = 1'b0;
    tick();
    chk(64'(feature_en), 64'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
